/* File: core/pst_pin_cell.sv */
// one pad driver: turns a pin action into registered level, enable and pull-up
// assumes direction and data bits come from the port registers outside
`timescale 1ns/1ns
module pst_pin_cell
  import pst_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // selection
  input wire pst_act_t act,
  input wire logic ddr,
  input wire logic port_data_bit,
  input wire logic fn_val,
  // peripheral takeover
  input wire logic per_en,
  input wire logic per_oe,
  input wire logic per_val,
  // pad side
  output logic pad_out_q,
  output logic pad_oe_n_q,
  output logic pull_up_q
);

  logic pad_out_d;
  logic pad_oe_n_d;
  logic pull_up_d;
  logic pull_allowed;
  logic port_out;
  logic port_oe_n;

  // ----------------------------------------
  // port function and peripheral takeover
  // ----------------------------------------
  assign port_out = per_en ? per_val : port_data_bit;
  assign port_oe_n = per_en ? ~per_oe : ~ddr;

  always_comb
  begin
    pad_out_d = pad_out_q;
    pad_oe_n_d = pad_oe_n_q;
    unique case (act)
      PST_ACT_FLOAT:
      begin
        pad_oe_n_d = 1'b1;
      end
      PST_ACT_LOW:
      begin
        pad_out_d = 1'b0;
        pad_oe_n_d = 1'b0;
      end
      PST_ACT_HIGH:
      begin
        pad_out_d = 1'b1;
        pad_oe_n_d = 1'b0;
      end
      PST_ACT_FUNC:
      begin
        pad_out_d = fn_val;
        pad_oe_n_d = 1'b0;
      end
      PST_ACT_HOLD:
      begin
        // keep level and enable; a held input stays undriven
        pad_out_d = pad_out_q;
        pad_oe_n_d = pad_oe_n_q | ~ddr;
      end
      PST_ACT_PORT:
      begin
        pad_out_d = port_out;
        pad_oe_n_d = port_oe_n;
      end
      PST_ACT_STBY_PORT:
      begin
        // peripherals are reinitialised, plain port bits rule
        pad_out_d = port_data_bit;
        pad_oe_n_d = ~ddr;
      end
    endcase
  end

  // ----------------------------------------
  // pull-up on undriven port inputs
  // ----------------------------------------
  assign pull_allowed = (act == PST_ACT_HOLD) || (act == PST_ACT_PORT) || (act == PST_ACT_STBY_PORT);
  assign pull_up_d = pull_allowed & pad_oe_n_d & ~ddr & port_data_bit;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pad_out_q <= PAD_OUT_RST;
      pad_oe_n_q <= PAD_OE_N_RST;
      pull_up_q <= PULL_UP_RST;
    end
    else
    begin
      pad_out_q <= pad_out_d;
      pad_oe_n_q <= pad_oe_n_d;
      pull_up_q <= pull_up_d;
    end
  end

endmodule

/* File: core/pst_pin_state_control.sv */
// pin state control: selects drive, float, hold or port function for every pin
// assumes power state, mode straps, bus signals and port bits come from the core
`timescale 1ns/1ns
module pst_pin_state_control
  import pst_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // power state and mode straps
  input wire pst_power_t pwr_state,
  input wire logic [1:0] mode_pins,
  // bus side of the core
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_dout,
  input wire logic bus_drive,
  input wire logic address_strobe_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic bus_clk,
  input wire logic sys_clk,
  // port registers and peripherals
  input wire logic [PIN_COUNT-1:0] ddr,
  input wire logic [PIN_COUNT-1:0] port_data_bit,
  input wire logic [PIN_COUNT-1:0] per_en,
  input wire logic [PIN_COUNT-1:0] per_oe,
  input wire logic [PIN_COUNT-1:0] per_val,
  // pads
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out_q,
  output logic [PIN_COUNT-1:0] pad_oe_n_q,
  output logic [PIN_COUNT-1:0] pull_up_q,
  // status back to the core
  output pst_mode_t mode_q,
  output logic [7:0] bus_din_q,
  output logic [7:0] inport_q,
  output logic bus_wait_q
);

  // ----------------------------------------
  // mode latch
  // ----------------------------------------
  logic mode_code_ok;
  logic mode_capture;
  pst_mode_t mode_dec;
  pst_mode_t mode_d;

  assign mode_code_ok = (mode_pins == MODE_CODE_EXP16) || (mode_pins == MODE_CODE_EXPIO)
    || (mode_pins == MODE_CODE_SINGLE);
  assign mode_dec = (mode_pins == MODE_CODE_EXP16) ? PST_MODE_EXP16
    : (mode_pins == MODE_CODE_EXPIO) ? PST_MODE_EXPIO : PST_MODE_SINGLE;
  // straps are sampled only while the chip sits in reset
  assign mode_capture = (pwr_state == PST_RESET) && mode_code_ok;
  assign mode_d = mode_capture ? mode_dec : mode_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_q <= PST_MODE_SINGLE;
    else
      mode_q <= mode_d;
  end

  // ----------------------------------------
  // group of each pin index
  // ----------------------------------------
  function automatic pst_group_t group_of(input int idx);
    pst_group_t g;
    g = PST_G_GPIO;
    if (idx <= ADDR_HI)
      g = PST_G_ADDR;
    else if (idx <= DATA_HI)
      g = PST_G_DATA;
    else if (idx <= GPIO_HI)
      g = PST_G_GPIO;
    else if (idx <= INPORT_HI)
      g = PST_G_INPORT;
    else if (idx == ECLK_PIN)
      g = PST_G_ECLK;
    else if (idx == WAIT_PIN)
      g = PST_G_WAIT;
    else if (idx == SYSCLK_PIN)
      g = PST_G_SYSCLK;
    else
      g = PST_G_STROBE;
    return g;
  endfunction

  // ----------------------------------------
  // single-chip pattern shared by bus pins
  // ----------------------------------------
  function automatic pst_act_t single_chip_act(input pst_power_t p);
    pst_act_t a;
    a = PST_ACT_FLOAT;
    unique case (p)
      PST_RESET: a = PST_ACT_FLOAT;
      PST_HW_STBY: a = PST_ACT_FLOAT;
      PST_SW_STBY: a = PST_ACT_HOLD;
      PST_SLEEP: a = PST_ACT_HOLD;
      PST_NORMAL: a = PST_ACT_PORT;
    endcase
    return a;
  endfunction

  // ----------------------------------------
  // action table: group x power state x mode
  // ----------------------------------------
  function automatic pst_act_t act_sel(
    input pst_group_t g,
    input pst_power_t p,
    input pst_mode_t m,
    input logic dir,
    input logic drv
  );
    pst_act_t a;
    logic m1;
    logic m2;
    logic exp;
    m1 = (m == PST_MODE_EXP16);
    m2 = (m == PST_MODE_EXPIO);
    exp = m1 | m2;
    a = PST_ACT_FLOAT;
    unique case (g)
      PST_G_ADDR:
      begin
        unique case (p)
          PST_RESET: a = m1 ? PST_ACT_LOW : PST_ACT_FLOAT;
          PST_HW_STBY: a = PST_ACT_FLOAT;
          PST_SW_STBY: a = m1 ? PST_ACT_LOW : ((m2 && dir) ? PST_ACT_LOW : PST_ACT_HOLD);
          PST_SLEEP: a = PST_ACT_HOLD;
          PST_NORMAL: a = m1 ? PST_ACT_FUNC : (m2 ? (dir ? PST_ACT_FUNC : PST_ACT_FLOAT) : PST_ACT_PORT);
        endcase
      end
      PST_G_DATA:
      begin
        if (exp)
          a = (p == PST_NORMAL && drv) ? PST_ACT_FUNC : PST_ACT_FLOAT;
        else
          a = single_chip_act(p);
      end
      PST_G_GPIO:
      begin
        unique case (p)
          PST_RESET: a = PST_ACT_FLOAT;
          PST_HW_STBY: a = PST_ACT_FLOAT;
          PST_SW_STBY: a = PST_ACT_STBY_PORT;
          PST_SLEEP: a = PST_ACT_HOLD;
          PST_NORMAL: a = PST_ACT_PORT;
        endcase
      end
      PST_G_INPORT:
      begin
        a = PST_ACT_FLOAT;
      end
      PST_G_ECLK:
      begin
        if (exp)
        begin
          unique case (p)
            PST_RESET: a = PST_ACT_FUNC;
            PST_HW_STBY: a = PST_ACT_FLOAT;
            PST_SW_STBY: a = dir ? PST_ACT_LOW : PST_ACT_FLOAT;
            PST_SLEEP: a = dir ? PST_ACT_FUNC : PST_ACT_FLOAT;
            PST_NORMAL: a = dir ? PST_ACT_FUNC : PST_ACT_FLOAT;
          endcase
        end
        else
          a = single_chip_act(p);
      end
      PST_G_WAIT:
      begin
        if (exp)
          a = PST_ACT_FLOAT;
        else
          a = single_chip_act(p);
      end
      PST_G_SYSCLK:
      begin
        unique case (p)
          PST_RESET: a = exp ? PST_ACT_FUNC : PST_ACT_FLOAT;
          PST_HW_STBY: a = PST_ACT_FLOAT;
          PST_SW_STBY: a = (exp || dir) ? PST_ACT_HIGH : PST_ACT_FLOAT;
          PST_SLEEP: a = (exp || dir) ? PST_ACT_FUNC : PST_ACT_FLOAT;
          PST_NORMAL: a = (exp || dir) ? PST_ACT_FUNC : PST_ACT_FLOAT;
        endcase
      end
      PST_G_STROBE:
      begin
        if (exp)
        begin
          unique case (p)
            PST_RESET: a = PST_ACT_HIGH;
            PST_HW_STBY: a = PST_ACT_FLOAT;
            PST_SW_STBY: a = PST_ACT_HIGH;
            PST_SLEEP: a = PST_ACT_HIGH;
            PST_NORMAL: a = PST_ACT_FUNC;
          endcase
        end
        else
          a = single_chip_act(p);
      end
    endcase
    return a;
  endfunction

  // ----------------------------------------
  // function values on the flat pin vector
  // ----------------------------------------
  logic [PIN_COUNT-1:0] fn_val;
  logic expanded;
  logic normal_run;

  assign fn_val = {read_strobe_n, write_strobe_n, address_strobe_n, sys_clk, 1'b0, bus_clk,
    BYTE_RST, GPIO_FN_NONE, bus_dout, bus_addr};
  assign expanded = (mode_q != PST_MODE_SINGLE);
  assign normal_run = (pwr_state == PST_NORMAL);

  // ----------------------------------------
  // one pad cell per pin
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      pst_act_t act;
      logic dir_eff;
      // mode 1 address pins are outputs whatever their direction bit, so sleep keeps the address
      assign dir_eff = ddr[gi] | ((mode_q == PST_MODE_EXP16) && (gi <= ADDR_HI));
      assign act = act_sel(group_of(gi), pwr_state, mode_q, ddr[gi], bus_drive);
      pst_pin_cell u_cell (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .act(act),
        .ddr(dir_eff),
        .port_data_bit(port_data_bit[gi]),
        .fn_val(fn_val[gi]),
        .per_en(per_en[gi]),
        .per_oe(per_oe[gi]),
        .per_val(per_val[gi]),
        .pad_out_q(pad_out_q[gi]),
        .pad_oe_n_q(pad_oe_n_q[gi]),
        .pull_up_q(pull_up_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // inputs seen by the core
  // ----------------------------------------
  logic [7:0] bus_din_d;
  logic [7:0] inport_d;
  logic bus_wait_d;
  logic wait_live;

  assign wait_live = expanded && normal_run;
  assign bus_din_d = (expanded && normal_run) ? pad_in[DATA_HI:DATA_LO] : bus_din_q;
  assign inport_d = normal_run ? pad_in[INPORT_HI:INPORT_LO] : inport_q;
  // wait pin is active low on the pad
  assign bus_wait_d = wait_live & ~pad_in[WAIT_PIN];

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_din_q <= BYTE_RST;
      inport_q <= BYTE_RST;
      bus_wait_q <= 1'b0;
    end
    else
    begin
      bus_din_q <= bus_din_d;
      inport_q <= inport_d;
      bus_wait_q <= bus_wait_d;
    end
  end

endmodule

/* File: core/pst_pkg.sv */
// pin state control package: pin layout, power states, modes, pin actions
// assumes the power state and mode straps come from the system controller
package pst_pkg;

  // ----------------------------------------
  // pin index layout of the flat pin vector
  // ----------------------------------------
  localparam int PIN_COUNT = 66;
  localparam int ADDR_LO = 0;
  localparam int ADDR_HI = 15;
  localparam int DATA_LO = 16;
  localparam int DATA_HI = 23;
  localparam int GPIO_LO = 24;
  localparam int GPIO_HI = 51;
  localparam int INPORT_LO = 52;
  localparam int INPORT_HI = 59;
  localparam int ECLK_PIN = 60;
  localparam int WAIT_PIN = 61;
  localparam int SYSCLK_PIN = 62;
  localparam int STROBE_LO = 63;
  localparam int STROBE_HI = 65;

  // ----------------------------------------
  // mode strap codes and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_CODE_EXP16 = 2'h1;
  localparam logic [1:0] MODE_CODE_EXPIO = 2'h2;
  localparam logic [1:0] MODE_CODE_SINGLE = 2'h3;
  localparam logic PAD_OUT_RST = 1'h0;
  localparam logic PAD_OE_N_RST = 1'h1;
  localparam logic PULL_UP_RST = 1'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [27:0] GPIO_FN_NONE = 28'h0000000;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [2:0] {
    PST_RESET,
    PST_HW_STBY,
    PST_SW_STBY,
    PST_SLEEP,
    PST_NORMAL
  } pst_power_t;

  typedef enum logic [1:0] {
    PST_MODE_EXP16,
    PST_MODE_EXPIO,
    PST_MODE_SINGLE
  } pst_mode_t;

  typedef enum logic [2:0] {
    PST_G_ADDR,
    PST_G_DATA,
    PST_G_GPIO,
    PST_G_INPORT,
    PST_G_ECLK,
    PST_G_WAIT,
    PST_G_SYSCLK,
    PST_G_STROBE
  } pst_group_t;

  // what a pin does in the current state
  typedef enum logic [2:0] {
    PST_ACT_FLOAT,
    PST_ACT_LOW,
    PST_ACT_HIGH,
    PST_ACT_FUNC,
    PST_ACT_HOLD,
    PST_ACT_PORT,
    PST_ACT_STBY_PORT
  } pst_act_t;

endpackage

/* File: testbench/pst_bus_partner.sv */
// expansion bus partner: resolves every pad level from device and far side drive
// assumes a read is a driven low level on the read strobe pin
`timescale 1ns/1ns
module pst_bus_partner
  import pst_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // device pads
  input wire logic [PIN_COUNT-1:0] pad_out_q,
  input wire logic [PIN_COUNT-1:0] pad_oe_n_q,
  input wire logic [PIN_COUNT-1:0] pull_up_q,
  // stall request
  input wire logic wait_req_n,
  // resolved levels
  output logic [PIN_COUNT-1:0] pad_in
);
  logic toggle_q = 1'h0;
  logic rd_sel;
  logic [7:0] mem_byte;

  // released lines wander so a stale level never looks valid
  always_ff @(posedge ref_clk)
    toggle_q <= ~toggle_q;
  assign rd_sel = !pad_oe_n_q[STROBE_HI] && !pad_out_q[STROBE_HI];
  assign mem_byte = pad_out_q[7:0] ^ 8'h5a;

  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      if (!pad_oe_n_q[i])
        pad_in[i] = pad_out_q[i];
      else if (i >= DATA_LO && i <= DATA_HI && rd_sel)
        pad_in[i] = mem_byte[i - DATA_LO];
      else if (i == WAIT_PIN)
        pad_in[i] = wait_req_n;
      else if (pull_up_q[i])
        pad_in[i] = 1'h1;
      else
        pad_in[i] = toggle_q ^ i[0];
    end
  end
endmodule

/* File: testbench/pst_pin_state_control_props.sv */
// checker for pin state control: pad enables and levels against state and mode
// assumes it is bound into the top module and sees only its ports
`timescale 1ns/1ns
module pst_pin_state_control_chk
  import pst_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire pst_power_t pwr_state,
  input wire logic [1:0] mode_pins,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_dout,
  input wire logic bus_drive,
  input wire logic [PIN_COUNT-1:0] ddr,
  input wire logic [PIN_COUNT-1:0] port_data_bit,
  input wire logic [PIN_COUNT-1:0] pad_in,
  input wire logic [PIN_COUNT-1:0] pad_out_q,
  input wire logic [PIN_COUNT-1:0] pad_oe_n_q,
  input wire logic [PIN_COUNT-1:0] pull_up_q,
  input wire pst_mode_t mode_q,
  input wire logic [7:0] inport_q,
  input wire logic bus_wait_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire ext = (mode_q != PST_MODE_SINGLE);

  mode_latch_a: assert property (pwr_state == PST_RESET && mode_pins != 2'h0 |=>
    mode_q == $past(mode_pins) - 2'h1) else $error("mode not latched");
  mode_keep_a: assert property (pwr_state == PST_RESET && mode_pins == 2'h0 |=> $stable(mode_q))
    else $error("illegal mode code taken");
  hw_float_a: assert property (pwr_state == PST_HW_STBY |=> &pad_oe_n_q) else $error("pin driven in hw standby");
  addr_out_a: assert property (mode_q == PST_MODE_EXP16 && pwr_state == PST_NORMAL |=>
    pad_out_q[ADDR_HI:ADDR_LO] == $past(bus_addr) && pad_oe_n_q[ADDR_HI:ADDR_LO] == 16'h0000)
    else $error("address not driven");
  addr_stby_a: assert property (mode_q == PST_MODE_EXPIO && pwr_state == PST_SW_STBY |=>
    ((pad_oe_n_q[ADDR_HI:ADDR_LO] | pad_out_q[ADDR_HI:ADDR_LO]) & $past(ddr[ADDR_HI:ADDR_LO])) == 16'h0000)
    else $error("address output not low");
  data_float_a: assert property (ext && !(pwr_state == PST_NORMAL && bus_drive) |=>
    &pad_oe_n_q[DATA_HI:DATA_LO]) else $error("data driven when idle");
  data_drive_a: assert property (ext && pwr_state == PST_NORMAL && bus_drive |=>
    pad_out_q[DATA_HI:DATA_LO] == $past(bus_dout) && pad_oe_n_q[DATA_HI:DATA_LO] == 8'h00)
    else $error("data not driven");
  strobe_high_a: assert property (ext && pwr_state inside {PST_RESET, PST_SW_STBY, PST_SLEEP} |=>
    pad_out_q[STROBE_HI:STROBE_LO] == 3'h7 && pad_oe_n_q[STROBE_HI:STROBE_LO] == 3'h0)
    else $error("strobes not high");
  clk_high_a: assert property (ext && pwr_state == PST_SW_STBY |=>
    pad_out_q[SYSCLK_PIN] && !pad_oe_n_q[SYSCLK_PIN]) else $error("system clock pin not high");
  eclk_low_a: assert property (ext && pwr_state == PST_SW_STBY && ddr[ECLK_PIN] |=>
    !pad_out_q[ECLK_PIN] && !pad_oe_n_q[ECLK_PIN]) else $error("bus clock pin not low");
  gpio_hold_a: assert property (pwr_state == PST_SLEEP |=>
    pad_out_q[GPIO_HI:GPIO_LO] == $past(pad_out_q[GPIO_HI:GPIO_LO]) &&
    pad_oe_n_q[GPIO_HI:GPIO_LO] == ($past(pad_oe_n_q[GPIO_HI:GPIO_LO]) | ~$past(ddr[GPIO_HI:GPIO_LO])))
    else $error("held port changed");
  gpio_pull_a: assert property (pwr_state == PST_SLEEP |=> pull_up_q[GPIO_HI:GPIO_LO] ==
    (pad_oe_n_q[GPIO_HI:GPIO_LO] & ~$past(ddr[GPIO_HI:GPIO_LO]) & $past(port_data_bit[GPIO_HI:GPIO_LO])))
    else $error("pull-up wrong");
  stby_port_a: assert property (pwr_state == PST_SW_STBY |=>
    pad_oe_n_q[GPIO_HI:GPIO_LO] == ~$past(ddr[GPIO_HI:GPIO_LO]) &&
    pad_out_q[GPIO_HI:GPIO_LO] == $past(port_data_bit[GPIO_HI:GPIO_LO])) else $error("port not released");
  wait_in_a: assert property (ext && pwr_state == PST_NORMAL |=> bus_wait_q == !$past(pad_in[WAIT_PIN]))
    else $error("wait request lost");
  inport_cap_a: assert property (pwr_state == PST_NORMAL |=>
    inport_q == $past(pad_in[INPORT_HI:INPORT_LO]) && &pad_oe_n_q[INPORT_HI:INPORT_LO])
    else $error("input port wrong");
endmodule

bind pst_pin_state_control pst_pin_state_control_chk u_chk (.ref_clk, .rst_b, .pwr_state, .mode_pins,
  .bus_addr, .bus_dout, .bus_drive, .ddr, .port_data_bit, .pad_in, .pad_out_q, .pad_oe_n_q, .pull_up_q,
  .mode_q, .inport_q, .bus_wait_q);

/* File: testbench/pst_pin_state_control_test.sv */
// bench for pin state control: walks modes and power states, checks pads against a model
// assumes the partner resolves all pads; inputs change at the falling edge
`timescale 1ns/1ns
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %s", $time, m); end end
module pst_pin_state_control_test
  import pst_pkg::*;
;
  typedef struct packed {
    logic [PIN_COUNT-1:0] oe_n;
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] pull;
    logic [7:0] din;
    logic [7:0] inp;
    logic wt;
    logic [1:0] mode;
  } pst_note_t;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  pst_power_t pwr_state = PST_RESET;
  logic [1:0] mode_pins = 2'h1;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_dout = 8'h00;
  logic bus_drive = 1'h0;
  logic [2:0] strobes = 3'h7;
  logic [1:0] clks = 2'h0;
  logic wait_req_n = 1'h1;
  logic [PIN_COUNT-1:0] ddr = '0, port_data_bit = '0, per_en = '0, per_oe = '0, per_val = '0;
  logic [PIN_COUNT-1:0] pad_in, pad_out_q, pad_oe_n_q, pull_up_q;
  pst_mode_t mode_q;
  logic [7:0] bus_din_q, inport_q;
  logic bus_wait_q;
  int fails = 0;
  int n_checks = 0;
  int mq = 3;
  logic [15:0] seed = 16'h6855;
  pst_note_t notes[$];
  pst_note_t m;
  event seen;

  pst_pin_state_control u_dut (.ref_clk, .rst_b, .pwr_state, .mode_pins, .bus_addr, .bus_dout, .bus_drive,
    .address_strobe_n(strobes[0]), .write_strobe_n(strobes[1]), .read_strobe_n(strobes[2]),
    .bus_clk(clks[0]), .sys_clk(clks[1]), .ddr, .port_data_bit, .per_en, .per_oe, .per_val, .pad_in,
    .pad_out_q, .pad_oe_n_q, .pull_up_q, .mode_q, .bus_din_q, .inport_q, .bus_wait_q);
  pst_bus_partner u_partner (.ref_clk, .pad_out_q, .pad_oe_n_q, .pull_up_q, .wait_req_n, .pad_in);

  initial
    forever #25 ref_clk = ~ref_clk;

  function automatic logic [15:0] nxt();
    seed = {1'h0, seed[15:1]} ^ (seed[0] ? 16'hb400 : 16'h0000);
    return seed;
  endfunction

  function automatic logic [PIN_COUNT-1:0] r66();
    logic [79:0] v;
    v = {nxt(), nxt(), nxt(), nxt(), nxt()};
    return v[PIN_COUNT-1:0];
  endfunction

  // expected action of pin i, using the mode latched before this edge
  function automatic pst_act_t act_of(int i, pst_power_t p, logic d);
    pst_act_t s;
    s = (p == PST_RESET) ? PST_ACT_FLOAT : (p == PST_NORMAL) ? PST_ACT_PORT : PST_ACT_HOLD;
    if (p == PST_HW_STBY || (i >= INPORT_LO && i <= INPORT_HI)) return PST_ACT_FLOAT;
    if (i >= GPIO_LO && i <= GPIO_HI) return (p == PST_SW_STBY) ? PST_ACT_STBY_PORT : s;
    if (i == SYSCLK_PIN) return (p == PST_RESET) ? (mq != 3 ? PST_ACT_FUNC : PST_ACT_FLOAT) :
      !(mq != 3 || d) ? PST_ACT_FLOAT : (p == PST_SW_STBY) ? PST_ACT_HIGH : PST_ACT_FUNC;
    if (mq == 3) return s;
    if (i <= ADDR_HI && mq == 1) return (p == PST_SLEEP) ? PST_ACT_HOLD : (p == PST_NORMAL) ? PST_ACT_FUNC : PST_ACT_LOW;
    if (i <= ADDR_HI) return (p == PST_RESET) ? PST_ACT_FLOAT : (p == PST_SLEEP) ? PST_ACT_HOLD :
      (p == PST_SW_STBY) ? (d ? PST_ACT_LOW : PST_ACT_HOLD) : (d ? PST_ACT_FUNC : PST_ACT_FLOAT);
    if (i <= DATA_HI) return (p == PST_NORMAL && bus_drive) ? PST_ACT_FUNC : PST_ACT_FLOAT;
    if (i == ECLK_PIN) return (p == PST_RESET) ? PST_ACT_FUNC : !d ? PST_ACT_FLOAT :
      (p == PST_SW_STBY) ? PST_ACT_LOW : PST_ACT_FUNC;
    if (i == WAIT_PIN) return PST_ACT_FLOAT;
    return (p == PST_NORMAL) ? PST_ACT_FUNC : PST_ACT_HIGH;
  endfunction

  // one edge: random inputs at the falling edge, note the expectation, release the monitor
  task automatic step(input pst_power_t p, input logic [1:0] sp);
    logic [PIN_COUNT-1:0] snap;
    logic [15:0] r;
    pst_act_t a;
    logic f;
    logic dd;
    r = nxt();
    pwr_state = p;
    mode_pins = sp;
    ddr = r66();
    port_data_bit = r66();
    per_en = r66() & r66();
    per_oe = r66();
    per_val = r66();
    bus_addr = nxt();
    {wait_req_n, clks, strobes, bus_drive, bus_dout} = r[14:0];
    #1;
    snap = pad_in;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      a = act_of(i, p, ddr[i]);
      // mode 1 address pins count as outputs when held
      dd = ddr[i] | (mq == 1 && i <= ADDR_HI);
      f = (i <= ADDR_HI) ? bus_addr[i] : (i <= DATA_HI) ? bus_dout[i - DATA_LO] : (i == ECLK_PIN) ? clks[0] :
        (i == SYSCLK_PIN) ? clks[1] : strobes[i - STROBE_LO];
      case (a)
        PST_ACT_FLOAT: m.oe_n[i] = 1'h1;
        PST_ACT_LOW: {m.oe_n[i], m.out[i]} = 2'h0;
        PST_ACT_HIGH: {m.oe_n[i], m.out[i]} = 2'h1;
        PST_ACT_FUNC: {m.oe_n[i], m.out[i]} = {1'h0, f};
        PST_ACT_HOLD: m.oe_n[i] = m.oe_n[i] | ~dd;
        PST_ACT_PORT: {m.oe_n[i], m.out[i]} = per_en[i] ? {~per_oe[i], per_val[i]} : {~ddr[i], port_data_bit[i]};
        default: {m.oe_n[i], m.out[i]} = {~ddr[i], port_data_bit[i]};
      endcase
      m.pull[i] = (a >= PST_ACT_HOLD) && m.oe_n[i] && !dd && port_data_bit[i];
    end
    if (p == PST_NORMAL)
      m.inp = snap[INPORT_HI:INPORT_LO];
    if (p == PST_NORMAL && mq != 3)
      m.din = snap[DATA_HI:DATA_LO];
    m.wt = (p == PST_NORMAL && mq != 3) && !snap[WAIT_PIN];
    if (p == PST_RESET && sp != 2'h0)
      mq = sp;
    m.mode = 2'(mq - 1);
    notes.push_back(m);
    @(negedge ref_clk);
    -> seen;
  endtask

  initial
  begin
    pst_note_t e;
    logic [PIN_COUNT-1:0] d;
    forever
    begin
      @(seen);
      e = notes.pop_front();
      d = (pad_oe_n_q ^ e.oe_n) | (pad_out_q ^ e.out);
      `CHK(d[ADDR_HI:ADDR_LO], 16'h0000, "address pins")
      `CHK(d[DATA_HI:DATA_LO], 8'h00, "data pins")
      `CHK(d[GPIO_HI:GPIO_LO], 28'h0000000, "port pins")
      `CHK(d[INPORT_HI:INPORT_LO], 8'h00, "input port pins")
      `CHK(d[ECLK_PIN], 1'h0, "bus clock pin")
      `CHK(d[WAIT_PIN], 1'h0, "wait pin")
      `CHK(d[SYSCLK_PIN], 1'h0, "system clock pin")
      `CHK(d[STROBE_HI:STROBE_LO], 3'h0, "strobe pins")
      `CHK(pull_up_q, e.pull, "pull-ups")
      `CHK(mode_q, e.mode, "latched mode")
      `CHK({bus_din_q, inport_q, bus_wait_q}, {e.din, e.inp, e.wt}, "captured inputs")
    end
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog: the run needs about 51 cycles
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    conclude();
  end

  initial
  begin
    static pst_power_t seq[14] = '{PST_NORMAL, PST_SW_STBY, PST_SLEEP, PST_NORMAL, PST_SLEEP, PST_SW_STBY, PST_HW_STBY,
      PST_NORMAL, PST_SW_STBY, PST_SLEEP, PST_NORMAL, PST_HW_STBY, PST_RESET, PST_NORMAL};
    m = '{oe_n: '1, out: '0, pull: '0, din: 8'h00, inp: 8'h00, wt: 1'h0, mode: 2'h2};
    repeat (3) @(negedge ref_clk);
    notes.push_back(m);
    -> seen;
    rst_b = 1'h1;
    for (int k = 1; k <= 3; k++)
    begin
      step(PST_RESET, 2'(k));
      step(PST_RESET, 2'h0);
      foreach (seq[j])
        step(seq[j], 2'(k));
      $display("mode %0d test done", k);
    end
    conclude();
  end
endmodule
